// ===== fpxm_exc_unit.v
// Floating-point exception detection and masked response unit, top.
// Assumes a datapath on the same clock hands over one unrounded result
// per OP_VALID_IN pulse, with operand classification beside it.
//
// Behaviour
// - A too-large result flags overflow and, if masked, becomes infinity.
// - Division of a finite nonzero dividend by zero flags zero divisor.
// - A masked zero divisor delivers infinity as the quotient.
// - A nonzero result below the smallest normal flags underflow.
// - A masked underflow shifts the significand right to a denormal.
// - A denormal operand or result flags the denormalized operand event.
// - A masked denormal operand leaves the result untouched.
// - A result that loses bits is rounded and flags inexact.
// - A masked inexact just delivers the rounded result.
// - Control holds six mask bits low and a global interrupt mask bit.
// - A two-bit control field selects the rounding mode.
// - Every event is posted in status; overflow and underflow defaults apply only when masked.
// - An unmasked event requests an interrupt unless globally masked.
`timescale 1ns/100ps
`default_nettype none
`include "fpxm_map.vh"

module fpxm_exc_unit (
   input  wire                      SYS_CLK_IN,
   input  wire                      SRST_IN,
   input  wire                      CE_IN,
   // Register port
   input  wire [`FPXM_ADDR_W-1:0]   ADDR_IN,
   input  wire [`FPXM_DATA_W-1:0]   WR_DATA_IN,
   input  wire                      WR_IN,
   input  wire                      RD_IN,
   output reg  [`FPXM_DATA_W-1:0]   RD_DATA_OUT,
   // Result from the datapath
   input  wire                      OP_VALID_IN,
   input  wire                      RES_SIGN_IN,
   input  wire [`FPXM_WEXP_W-1:0]   RES_EXP_IN,
   input  wire [`FPXM_XSIG_W-1:0]   RES_SIG_IN,
   input  wire                      OPND_DENORM_IN,
   input  wire                      DIV_IN,
   input  wire                      DIVISOR_ZERO_IN,
   input  wire                      DIVIDEND_ZERO_IN,
   input  wire                      DIVIDEND_INF_IN,
   // Delivered result
   output reg                       RESULT_VALID_OUT,
   output reg                       RESULT_SIGN_OUT,
   output reg  [`FPXM_EXP_W-1:0]    RESULT_EXP_OUT,
   output reg  [`FPXM_SIG_W-1:0]    RESULT_SIG_OUT,
   output reg  [`FPXM_EXC_W-1:0]    EXC_FLAGS_OUT,
   // Interrupts
   output reg                       EXC_IRQ_OUT,
   output reg                       INT_OUT
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////

   // Reset word kept as a named constant so its fields can be picked out
   localparam [`FPXM_DATA_W-1:0]    ctrl_rst = `FPXM_CTRL_RST;

   reg  [`FPXM_EXC_W-1:0]           mask;
   reg                              gmask;
   reg  [1:0]                       rc;
   reg  [`FPXM_EXC_W-1:0]           status;
   reg  [`FPXM_EXC_W-1:0]           int_en;
   reg                              p_zd;
   reg                              p_opden;

   wire                             r_valid;
   wire                             r_sign;
   wire [`FPXM_WEXP_W-1:0]          r_exp;
   wire [`FPXM_SIG_W-1:0]           r_sig;
   wire                             r_tiny;
   wire                             r_inexact;
   wire                             r_zero;
   wire                             zd_in;
   wire                             wr_ctrl;
   wire                             wr_clear;
   wire                             wr_inten;

   reg                              ev_ovf;
   reg                              ev_unf;
   reg                              ev_pre;
   reg                              ev_den;
   reg  [`FPXM_EXC_W-1:0]           events;
   wire [`FPXM_EXC_W-1:0]           clr;
   wire [`FPXM_EXC_W-1:0]           next_status;
   reg                              next_sign;
   reg  [`FPXM_EXP_W-1:0]           next_exp;
   reg  [`FPXM_SIG_W-1:0]           next_sig;
   reg  [`FPXM_DATA_W-1:0]          next_rd;

   ////////////////////////////////////////////////////////////////////
   // Register port decode
   ////////////////////////////////////////////////////////////////////

   // Write strobes per register; strobes never overlap, as each decodes its own address
   assign wr_ctrl  = WR_IN && (ADDR_IN == `FPXM_REG_CTRL);
   assign wr_clear = WR_IN && (ADDR_IN == `FPXM_REG_CLEAR);
   assign wr_inten = WR_IN && (ADDR_IN == `FPXM_REG_INTEN);

   // Control, interrupt enable; all exceptions masked after reset
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         mask   <= ctrl_rst[`FPXM_EXC_W-1:0];
         gmask  <= ctrl_rst[`FPXM_BIT_GMASK];
         rc     <= ctrl_rst[`FPXM_RC_HI:`FPXM_RC_LO];
         int_en <= `FPXM_EXC_ZERO;
      end else if (CE_IN) begin
         if (wr_ctrl) begin
            mask  <= WR_DATA_IN[`FPXM_EXC_W-1:0];
            gmask <= WR_DATA_IN[`FPXM_BIT_GMASK];
            rc    <= WR_DATA_IN[`FPXM_RC_HI:`FPXM_RC_LO];
         end
         if (wr_inten) begin
            int_en <= WR_DATA_IN[`FPXM_EXC_W-1:0];
         end
      end
   end

   // Read mux; clear register is write-only and reads zero
   always @* begin
      next_rd = `FPXM_DATA_ZERO;
      if (RD_IN) begin
         case (ADDR_IN)
            `FPXM_REG_CTRL: begin
               next_rd[`FPXM_EXC_W-1:0]         = mask;
               next_rd[`FPXM_BIT_GMASK]         = gmask;
               next_rd[`FPXM_RC_HI:`FPXM_RC_LO] = rc;
            end
            `FPXM_REG_STATUS: next_rd[`FPXM_EXC_W-1:0] = status;
            `FPXM_REG_INTEN:  next_rd[`FPXM_EXC_W-1:0] = int_en;
            default:          next_rd = `FPXM_DATA_ZERO;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         RD_DATA_OUT <= `FPXM_DATA_ZERO;
      end else if (CE_IN) begin
         RD_DATA_OUT <= next_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Stage 1: gradual underflow and rounding
   ////////////////////////////////////////////////////////////////////

   // zero divisor with finite nonzero dividend
   assign zd_in = DIV_IN && DIVISOR_ZERO_IN &&
                  !DIVIDEND_ZERO_IN && !DIVIDEND_INF_IN;

   // Denormalizing only when underflow is masked keeps the unmasked
   // case in normal form for a trap handler to rescale
   fpxm_round u_round (
      .clk_in       (SYS_CLK_IN),
      .srst_in      (SRST_IN),
      .ce_in        (CE_IN),
      .valid_in     (OP_VALID_IN),
      .sign_in      (RES_SIGN_IN),
      .exp_in       (RES_EXP_IN),
      .sig_in       (RES_SIG_IN),
      .rc_in        (rc),
      .denorm_en_in (mask[`FPXM_BIT_UNF]),
      .valid_out    (r_valid),
      .sign_out     (r_sign),
      .exp_out      (r_exp),
      .sig_out      (r_sig),
      .tiny_out     (r_tiny),
      .inexact_out  (r_inexact),
      .zero_out     (r_zero)
   );

   // Side flags travel alongside the rounder stage
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         p_zd    <= 1'b0;
         p_opden <= 1'b0;
      end else if (CE_IN) begin
         p_zd    <= zd_in;
         p_opden <= OPND_DENORM_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Stage 2: detection and default results
   ////////////////////////////////////////////////////////////////////

   // A zero divisor suppresses the result-based events; the
   // rounder output is meaningless for that case
   always @* begin
      // magnitude beyond the largest finite exponent
      ev_ovf = !p_zd && !r_zero &&
               ($signed(r_exp) >= $signed(`FPXM_WEXP_MAX));
      ev_unf = !p_zd && r_tiny;
      // lost bits; a masked overflow is inexact as well
      ev_pre = !p_zd && (r_inexact || (ev_ovf && mask[`FPXM_BIT_OVF]));
      // denormal operand, or a denormal result
      ev_den = p_opden || (!p_zd && (r_exp == `FPXM_WEXP_ZERO) &&
                           (r_sig != `FPXM_SIG_ZERO));
      events = `FPXM_EXC_ZERO;
      if (r_valid) begin
         events[`FPXM_BIT_DEN] = ev_den;
         events[`FPXM_BIT_ZD]  = p_zd;
         events[`FPXM_BIT_OVF] = ev_ovf;
         events[`FPXM_BIT_UNF] = ev_unf;
         events[`FPXM_BIT_PRE] = ev_pre;
      end
   end

   // Default result selection
   always @* begin
      next_sign = r_sign;
      next_exp  = r_exp[`FPXM_EXP_W-1:0];
      next_sig  = r_sig;
      if (p_zd) begin
         next_exp = `FPXM_EXP_MAX;
         next_sig = `FPXM_SIG_INF;
      end else if (ev_ovf && mask[`FPXM_BIT_OVF]) begin
         next_exp = `FPXM_EXP_MAX;
         next_sig = `FPXM_SIG_INF;
      end
      // inexact: rounded value passes as is
   end

   // Result register, one valid pulse per operation
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         RESULT_VALID_OUT <= 1'b0;
         RESULT_SIGN_OUT  <= 1'b0;
         RESULT_EXP_OUT   <= `FPXM_EXP_ZERO;
         RESULT_SIG_OUT   <= `FPXM_SIG_ZERO;
         EXC_FLAGS_OUT    <= `FPXM_EXC_ZERO;
      end else if (CE_IN) begin
         RESULT_VALID_OUT <= r_valid;
         EXC_FLAGS_OUT    <= events;
         if (r_valid) begin
            RESULT_SIGN_OUT <= next_sign;
            RESULT_EXP_OUT  <= next_exp;
            RESULT_SIG_OUT  <= next_sig;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sticky status and interrupts
   ////////////////////////////////////////////////////////////////////

   // Per-bit sticky flags; a new event in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < `FPXM_EXC_W; gi = gi + 1) begin : g_stat
         assign clr[gi] = wr_clear && WR_DATA_IN[gi];
         // post every event, masked or not
         assign next_status[gi] = (status[gi] && !clr[gi]) || events[gi];
      end
   endgenerate

   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         status <= `FPXM_EXC_ZERO;
      end else if (CE_IN) begin
         status <= next_status;
      end
   end

   // Interrupt levels follow status one cycle later
   always @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         EXC_IRQ_OUT <= 1'b0;
         INT_OUT     <= 1'b0;
      end else if (CE_IN) begin
         // unmasked events, gated by the global mask
         EXC_IRQ_OUT <= (|(status & ~mask)) && !gmask;
         INT_OUT     <= |(status & int_en);
      end
   end

endmodule // fpxm_exc_unit

`default_nettype wire

// ===== fpxm_map.vh
// Constants for the floating-point exception detect and mask unit.
// Assumes the extended real format: 15-bit biased exponent, 64-bit
// significand with an explicit integer bit.
`ifndef FPXM_MAP_VH
`define FPXM_MAP_VH

// Register port
`define FPXM_ADDR_W      2
`define FPXM_DATA_W      16
`define FPXM_REG_CTRL    2'h0
`define FPXM_REG_STATUS  2'h1
`define FPXM_REG_CLEAR   2'h2
`define FPXM_REG_INTEN   2'h3
`define FPXM_CTRL_RST    16'h00BF
`define FPXM_DATA_ZERO   16'h0000

// Exception bit positions (mask, status, clear, enable)
`define FPXM_EXC_W       6
`define FPXM_BIT_INV     0
`define FPXM_BIT_DEN     1
`define FPXM_BIT_ZD      2
`define FPXM_BIT_OVF     3
`define FPXM_BIT_UNF     4
`define FPXM_BIT_PRE     5
`define FPXM_BIT_GMASK   7
`define FPXM_RC_LO       10
`define FPXM_RC_HI       11
`define FPXM_EXC_ZERO    6'h00
`define FPXM_EXC_ALL     6'h3F

// Rounding control codes
`define FPXM_RC_NEAR     2'h0
`define FPXM_RC_DOWN     2'h1
`define FPXM_RC_UP       2'h2
`define FPXM_RC_CHOP     2'h3

// Number format
`define FPXM_EXP_W       15
`define FPXM_SIG_W       64
`define FPXM_WEXP_W      17
`define FPXM_XSIG_W      67
`define FPXM_EXP_MAX     15'h7FFF
`define FPXM_EXP_ZERO    15'h0000
`define FPXM_WEXP_MAX    17'h07FFF
`define FPXM_WEXP_ONE    17'h00001
`define FPXM_WEXP_ZERO   17'h00000
`define FPXM_SIG_INF     64'h8000000000000000
`define FPXM_SIG_ZERO    64'h0000000000000000
`define FPXM_SH_MAX      7'h43

`endif

// ===== fpxm_round.v
// Gradual underflow shifter and rounder, one register stage.
// Assumes the incoming significand is normalized or zero, and the
// exponent is a signed, biased value that may lie out of range.
`timescale 1ns/100ps
`default_nettype none
`include "fpxm_map.vh"

module fpxm_round (
   input  wire                      clk_in,
   input  wire                      srst_in,
   input  wire                      ce_in,
   input  wire                      valid_in,
   input  wire                      sign_in,
   input  wire [`FPXM_WEXP_W-1:0]   exp_in,
   input  wire [`FPXM_XSIG_W-1:0]   sig_in,
   input  wire [1:0]                rc_in,
   input  wire                      denorm_en_in,
   output reg                       valid_out,
   output reg                       sign_out,
   output reg  [`FPXM_WEXP_W-1:0]   exp_out,
   output reg  [`FPXM_SIG_W-1:0]    sig_out,
   output reg                       tiny_out,
   output reg                       inexact_out,
   output reg                       zero_out
);

   wire signed [`FPXM_WEXP_W-1:0]   sexp;
   wire                             is_zero;
   wire                             tiny;
   wire [`FPXM_WEXP_W-1:0]          sh_full;
   wire [6:0]                       shamt;
   wire [2*`FPXM_XSIG_W-1:0]        wide;
   wire [`FPXM_XSIG_W-1:0]          shifted;
   wire                             guard;
   wire                             sticky;
   wire [`FPXM_SIG_W:0]             sum;
   wire [`FPXM_WEXP_W-1:0]          exp_adj;
   reg                              rnd_up;
   reg  [`FPXM_WEXP_W-1:0]          next_exp;
   reg  [`FPXM_SIG_W-1:0]           next_sig;

   assign sexp    = exp_in;
   assign is_zero = (sig_in == {`FPXM_XSIG_W{1'b0}});
   assign tiny    = !is_zero && (sexp < $signed(`FPXM_WEXP_ONE));
   assign sh_full = `FPXM_WEXP_ONE - exp_in;
   // shift right until exponent is minimum; shift saturates
   assign shamt   = !(tiny && denorm_en_in) ? 7'h00 :
                    (sh_full > {10'h000, `FPXM_SH_MAX}) ? `FPXM_SH_MAX :
                    sh_full[6:0];
   assign wide    = {sig_in, {`FPXM_XSIG_W{1'b0}}} >> shamt;
   assign shifted = wide[2*`FPXM_XSIG_W-1:`FPXM_XSIG_W];
   assign guard   = shifted[2];
   // Bits shifted out keep the sticky honest for deep underflow
   assign sticky  = (|shifted[1:0]) | (|wide[`FPXM_XSIG_W-1:0]);
   assign exp_adj = (shamt != 7'h00) ? `FPXM_WEXP_ZERO : exp_in;

   always @* begin
      case (rc_in)
         `FPXM_RC_NEAR: rnd_up = guard & (sticky | shifted[3]);
         `FPXM_RC_DOWN: rnd_up = sign_in & (guard | sticky);
         `FPXM_RC_UP:   rnd_up = !sign_in & (guard | sticky);
         default:       rnd_up = 1'b0;
      endcase
   end

   assign sum = {1'b0, shifted[`FPXM_XSIG_W-1:3]} + {{`FPXM_SIG_W{1'b0}}, rnd_up};

   // Carry out renormalizes; a denormal may round up into the normal range
   always @* begin
      next_sig = sum[`FPXM_SIG_W-1:0];
      next_exp = exp_adj;
      if (sum[`FPXM_SIG_W]) begin
         next_sig = sum[`FPXM_SIG_W:1];
         next_exp = exp_adj + `FPXM_WEXP_ONE;
      end else if (exp_adj == `FPXM_WEXP_ZERO && sum[`FPXM_SIG_W-1]) begin
         next_exp = `FPXM_WEXP_ONE;
      end
   end

   // Output stage, frozen while the clock enable is low
   always @(posedge clk_in) begin
      if (srst_in) begin
         valid_out   <= 1'b0;
         sign_out    <= 1'b0;
         exp_out     <= `FPXM_WEXP_ZERO;
         sig_out     <= `FPXM_SIG_ZERO;
         tiny_out    <= 1'b0;
         inexact_out <= 1'b0;
         zero_out    <= 1'b0;
      end else if (ce_in) begin
         valid_out   <= valid_in;
         sign_out    <= sign_in;
         exp_out     <= next_exp;
         sig_out     <= next_sig;
         tiny_out    <= tiny;
         inexact_out <= guard | sticky;
         zero_out    <= is_zero;
      end
   end

endmodule // fpxm_round

`default_nettype wire

// ===== fpxm_exc_chk.sv
// Port checker for the exception detect and mask unit.
// Assumes it is bound to fpxm_exc_unit and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "fpxm_map.vh"
module fpxm_exc_chk (
   input wire logic                    SYS_CLK_IN,
   input wire logic                    SRST_IN,
   input wire logic                    CE_IN,
   input wire logic                    WR_IN,
   input wire logic                    RD_IN,
   input wire logic [`FPXM_DATA_W-1:0] RD_DATA_OUT,
   input wire logic                    OP_VALID_IN,
   input wire logic                    OPND_DENORM_IN,
   input wire logic                    DIV_IN,
   input wire logic                    DIVISOR_ZERO_IN,
   input wire logic                    DIVIDEND_ZERO_IN,
   input wire logic                    DIVIDEND_INF_IN,
   input wire logic                    RESULT_VALID_OUT,
   input wire logic [`FPXM_EXP_W-1:0]  RESULT_EXP_OUT,
   input wire logic [`FPXM_SIG_W-1:0]  RESULT_SIG_OUT,
   input wire logic [`FPXM_EXC_W-1:0]  EXC_FLAGS_OUT,
   input wire logic                    EXC_IRQ_OUT,
   input wire logic                    INT_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);
   ////////////////////////////////////////////////////////////////////////////
   // Latency is fixed, so a stalled enable must be part of the cause
   res_lat_a: assert property (OP_VALID_IN && CE_IN ##1 CE_IN |=> RESULT_VALID_OUT)
      else $error("result late");
   flags_idle_a: assert property (!RESULT_VALID_OUT |-> EXC_FLAGS_OUT == `FPXM_EXC_ZERO)
      else $error("flags without result");
   zd_cause_a: assert property (OP_VALID_IN && CE_IN && DIV_IN && DIVISOR_ZERO_IN
      && !DIVIDEND_ZERO_IN && !DIVIDEND_INF_IN ##1 CE_IN
      |=> EXC_FLAGS_OUT[`FPXM_BIT_ZD]) else $error("zero divisor missed");
   zd_inf_a: assert property (RESULT_VALID_OUT && EXC_FLAGS_OUT[`FPXM_BIT_ZD]
      |-> RESULT_EXP_OUT == `FPXM_EXP_MAX && RESULT_SIG_OUT == `FPXM_SIG_INF)
      else $error("zero divisor result not infinity");
   den_opnd_a: assert property (OP_VALID_IN && CE_IN && OPND_DENORM_IN ##1 CE_IN
      |=> EXC_FLAGS_OUT[`FPXM_BIT_DEN]) else $error("denormal operand missed");
   rd_idle_a: assert property ($past(CE_IN) && !$past(RD_IN)
      |-> RD_DATA_OUT == `FPXM_DATA_ZERO) else $error("read data outside read slot");
   // Request may only rise after an event or a mask change
   irq_rise_a: assert property ($rose(EXC_IRQ_OUT)
      |-> $past(RESULT_VALID_OUT) || $past(WR_IN, 2)) else $error("request without cause");
   int_fall_a: assert property ($fell(INT_OUT) |-> $past(WR_IN, 2))
      else $error("interrupt dropped without write");
   zd_seen_c: cover property (RESULT_VALID_OUT && EXC_FLAGS_OUT[`FPXM_BIT_ZD]);
   irq_seen_c: cover property ($rose(EXC_IRQ_OUT));
   pre_seen_c: cover property (RESULT_VALID_OUT && EXC_FLAGS_OUT[`FPXM_BIT_PRE]);
endmodule // fpxm_exc_chk
bind fpxm_exc_unit fpxm_exc_chk u_fpxm_exc_chk (.SYS_CLK_IN(SYS_CLK_IN),
   .SRST_IN(SRST_IN), .CE_IN(CE_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RD_DATA_OUT(RD_DATA_OUT), .OP_VALID_IN(OP_VALID_IN), .OPND_DENORM_IN(OPND_DENORM_IN),
   .DIV_IN(DIV_IN), .DIVISOR_ZERO_IN(DIVISOR_ZERO_IN), .DIVIDEND_ZERO_IN(DIVIDEND_ZERO_IN),
   .DIVIDEND_INF_IN(DIVIDEND_INF_IN), .RESULT_VALID_OUT(RESULT_VALID_OUT),
   .RESULT_EXP_OUT(RESULT_EXP_OUT), .RESULT_SIG_OUT(RESULT_SIG_OUT),
   .EXC_FLAGS_OUT(EXC_FLAGS_OUT), .EXC_IRQ_OUT(EXC_IRQ_OUT), .INT_OUT(INT_OUT));
`default_nettype wire

// ===== fpxm_host_model.sv
// Host side model: takes one service request per rise of the request line.
// Assumes the request is a registered level on the same clock.
`timescale 1ns/100ps
`default_nettype none
module fpxm_host_model (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   input  wire logic       irq_in,
   output logic      [7:0] taken_out
);
   logic irq_d;
   // Edge count, since a level held high must not look like many requests
   always @(posedge clk_in) begin
      irq_d <= irq_in;
      if (srst_in) taken_out <= 8'h00;
      else if (irq_in && !irq_d) taken_out <= taken_out + 8'h01;
   end
endmodule // fpxm_host_model
`default_nettype wire

// ===== fpxm_exc_unit_bench.sv
// Self-checking bench for the exception unit, with the host model on its request.
// Assumes clock enable held high; negative results only in the rounding test.
`timescale 1ns/100ps
`default_nettype none
`include "fpxm_map.vh"
module fpxm_exc_unit_bench;
   logic        clk, srst, wr, rd, opv, den, div, dsz, ddz, ddi, rv, rs, irq, intr, sgn;
   logic [1:0]  addr;
   logic [15:0] wdata, rdata, d;
   logic [16:0] rexp;
   logic [66:0] rsig;
   logic [14:0] re;
   logic [63:0] rg;
   logic [5:0]  flags;
   logic [7:0]  taken;
   int          miscompares, checked, i;
   fpxm_exc_unit u_fpxm_exc_unit (.SYS_CLK_IN(clk), .SRST_IN(srst), .CE_IN(1'b1),
      .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata),
      .OP_VALID_IN(opv), .RES_SIGN_IN(sgn), .RES_EXP_IN(rexp), .RES_SIG_IN(rsig),
      .OPND_DENORM_IN(den), .DIV_IN(div), .DIVISOR_ZERO_IN(dsz), .DIVIDEND_ZERO_IN(ddz),
      .DIVIDEND_INF_IN(ddi), .RESULT_VALID_OUT(rv), .RESULT_SIGN_OUT(rs),
      .RESULT_EXP_OUT(re), .RESULT_SIG_OUT(rg), .EXC_FLAGS_OUT(flags),
      .EXC_IRQ_OUT(irq), .INT_OUT(intr));
   fpxm_host_model u_fpxm_host_model (.clk_in(clk), .srst_in(srst), .irq_in(irq),
      .taken_out(taken));
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic ck(input string n, input [63:0] e, input [63:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input [1:0] a, input [15:0] v);
      @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask
   // Read data stand only in the slot after the strobe
   task automatic rd_reg(input [1:0] a, output [15:0] v);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 v = rdata;
   endtask
   // One result in; the answer stands only in the second cycle after the taking edge
   task automatic op(input [16:0] e, input [66:0] g, input [4:0] k);
      @(posedge clk); opv <= 1'b1; rexp <= e; rsig <= g; {den, div, dsz, ddz, ddi} <= k;
      @(posedge clk); opv <= 1'b0;
      @(posedge clk);
      #1 ck("valid", 1, rv);
   endtask
   task automatic res(input [5:0] f, input [14:0] e, input [63:0] s);
      ck("flags", f, flags);
      ck("exp", e, re);
      ck("sig", s, rg);
   endtask
   task automatic wait2;
      repeat (2) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd_reg(`FPXM_REG_CTRL, d); ck("ctrl", `FPXM_CTRL_RST, d);
      wr_reg(`FPXM_REG_STATUS, 16'hFFFF);
      for (i = 1; i < 4; i++) begin
         rd_reg(i[1:0], d); ck("reg", 0, d);
      end
      wr_reg(`FPXM_REG_CTRL, 16'hFFFF);
      rd_reg(`FPXM_REG_CTRL, d); ck("ctrl", 16'h0CBF, d);
      wr_reg(`FPXM_REG_CTRL, `FPXM_CTRL_RST);
   endtask
   task automatic t_div;
      op(17'h03FFF, {64'hC000000000000000, 3'h0}, 5'h0C); res(6'h04, `FPXM_EXP_MAX, `FPXM_SIG_INF);
      op(17'h03FFF, {64'hC000000000000000, 3'h0}, 5'h0E); ck("flags", 0, flags);
      op(17'h03FFF, {64'hC000000000000000, 3'h0}, 5'h0D); ck("flags", 0, flags);
   endtask
   task automatic t_range;
      op(17'h07FFF, {`FPXM_SIG_INF, 3'h0}, 5'h00); res(6'h28, `FPXM_EXP_MAX, `FPXM_SIG_INF);
      op(17'h00000, {`FPXM_SIG_INF, 3'h0}, 5'h00); res(6'h12, 15'h0000, 64'h4000000000000000);
      op(17'h1FFFF, {`FPXM_SIG_INF, 3'h0}, 5'h00); res(6'h12, 15'h0000, 64'h2000000000000000);
      op(17'h03FFF, {`FPXM_SIG_INF, 3'h0}, 5'h10); res(6'h02, 15'h3FFF, `FPXM_SIG_INF);
   endtask
   // Above half: nearest rounds up, and the directed mode toward the sign's side
   task automatic t_round;
      for (i = 0; i < 8; i++) begin
         @(posedge clk) sgn <= i[2];
         wr_reg(`FPXM_REG_CTRL, {4'h0, i[1:0], 10'h0BF});
         op(17'h03FFF, {`FPXM_SIG_INF, 3'h6}, 5'h00);
         res(6'h20, 15'h3FFF, `FPXM_SIG_INF +
             ((i[1:0] == 2'h0 || i[1:0] == {!i[2], i[2]}) ? 1 : 0));
         ck("sign", i[2], rs);
      end
      @(posedge clk) sgn <= 1'b0;
      wr_reg(`FPXM_REG_CTRL, `FPXM_CTRL_RST);
   endtask
   task automatic t_irq;
      wr_reg(`FPXM_REG_CLEAR, 16'h003F);
      wr_reg(`FPXM_REG_CTRL, 16'h0037);
      op(17'h07FFF, {`FPXM_SIG_INF, 3'h0}, 5'h00);
      @(posedge clk); #1 ck("irq", 1, irq);
      // Host sees the rise one edge later
      @(posedge clk); #1 ck("taken", 1, taken);
      op(17'h03FFF, {64'hC000000000000000, 3'h4}, 5'h00);
      rd_reg(`FPXM_REG_STATUS, d); ck("status", 16'h0028, d);
      wr_reg(`FPXM_REG_CTRL, 16'h00B7); wait2; ck("irq", 0, irq);
      wr_reg(`FPXM_REG_INTEN, 16'h0008); wait2; ck("int", 1, intr);
      wr_reg(`FPXM_REG_CLEAR, 16'h0008); wait2; ck("int", 0, intr);
      rd_reg(`FPXM_REG_STATUS, d); ck("status", 16'h0020, d);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {clk, wr, rd, opv, den, div, dsz, ddz, ddi, sgn} = '0;
      {addr, wdata, rexp, rsig} = '0;
      srst = 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_regs;
      t_div;
      t_range;
      t_round;
      t_irq;
      results;
   end
   // Whole run is about 120 cycles; this only cuts a hang
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      $display("unexpected watchdog: expected end, seen timeout");
      results;
   end
endmodule // fpxm_exc_unit_bench
`default_nettype wire
